// ### common/iem_consts.svh
// Constants for the two-wire EEPROM random-read master
`ifndef IEM_CONSTS_SVH
`define IEM_CONSTS_SVH
// Status codes posted after each bus action
`define IEM_ST_START 8'h08
`define IEM_ST_RSTART 8'h10
`define IEM_ST_AW_ACK 8'h18
`define IEM_ST_AW_NACK 8'h20
`define IEM_ST_DT_ACK 8'h28
`define IEM_ST_DT_NACK 8'h30
`define IEM_ST_AR_ACK 8'h40
`define IEM_ST_AR_NACK 8'h48
`define IEM_ST_DR_ACK 8'h50
`define IEM_ST_DR_NACK 8'h58
`define IEM_ST_RELEASED 8'hF8
// Reset values
`define IEM_CODE_RST 8'hF8
`define IEM_BYTE_RST 8'h00
// Bit-time structure: four quarters per bit, nine bits per byte
`define IEM_QTR_FIRST 2'h0
`define IEM_QTR_RISE 2'h1
`define IEM_QTR_SAMPLE 2'h2
`define IEM_QTR_LAST 2'h3
`define IEM_BIT_FIRST 4'h0
`define IEM_ACK_BIT 4'h8
`define IEM_MSB 3'h7
`endif

// ### common/iem_pkg.sv
// Types for the two-wire EEPROM random-read master
package iem_pkg;
  // One software write to the control bits
  typedef struct packed {
    logic begin_req;
    logic halt_req;
    logic flag_clr;
    logic ack_assert;
  } iem_ctl_t;
  // Bus sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_HOLD,
    S_START,
    S_BYTE,
    S_STOP
  } iem_state_t;
endpackage

// ### rtl/iem_qtick.sv
// Quarter-bit tick generator for the serial clock
`timescale 1ns/100ps
`include "iem_consts.svh"
module iem_qtick (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic run_i,
  input wire logic [7:0] div_i,
  // Tick every div_i+1 clocks while running
  output logic tick_o
);
  logic [7:0] cnt_q; // Clocks since last tick

  // Counter restarts whenever the sequencer is parked
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 8'h00;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q <= 8'h00;
      tick_o <= 1'b0;
    end else if (cnt_q == div_i) begin
      cnt_q <= 8'h00;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick_o <= 1'b0;
    end
  end
endmodule

// ### rtl/iem_ctrl.sv
// Two-wire master sequencer for EEPROM random reads
`timescale 1ns/100ps
`include "iem_consts.svh"
module iem_ctrl import iem_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Control bits and data from software
  input wire logic ctl_wr_i,
  input wire iem_ctl_t ctl_i,
  input wire logic dat_wr_i,
  input wire logic [7:0] dat_i,
  input wire logic [7:0] rate_divider_i,
  // State seen by software
  output logic flag_o,
  output logic [7:0] bus_state_code_o,
  output logic [7:0] shift_byte_reg_o,
  output logic begin_cond_request_o,
  output logic halt_cond_request_o,
  output logic ack_assert_o,
  // Open-drain bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  iem_state_t state_q; // Sequencer state
  logic [1:0] qtr_q; // Quarter within bit
  logic [3:0] bit_q; // Bit within byte, 8 is ack
  logic started_q; // Bus owned since a START
  logic addr_ph_q; // Next byte is the address
  logic rd_q; // Read direction latched from address
  logic ack_q; // Partner acknowledged last byte
  logic tick; // Quarter-bit tick
  logic run; // Sequencer busy on the bus
  logic go; // Software cleared flag while parked
  logic last; // Final quarter of a phase
  logic start_done;
  logic byte_done;
  logic stop_done;
  logic rx_data; // Current byte is received data

  assign run = (state_q == S_START) || (state_q == S_BYTE) || (state_q == S_STOP);
  assign go = ctl_wr_i && ctl_i.flag_clr && ((state_q == S_IDLE) || (state_q == S_HOLD));
  assign last = tick && (qtr_q == `IEM_QTR_LAST);
  assign start_done = (state_q == S_START) && last;
  assign byte_done = (state_q == S_BYTE) && last && (bit_q == `IEM_ACK_BIT);
  assign stop_done = (state_q == S_STOP) && last;
  assign rx_data = rd_q && !addr_ph_q;

  // Quarter ticks pace every bus phase
  iem_qtick u_qtick (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .run_i(run),
    .div_i(rate_divider_i),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next action chosen from the bits written with the flag clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= S_IDLE;
    end else if (go) begin
      if (ctl_i.halt_req && started_q) begin
        state_q <= S_STOP;
      end else if (ctl_i.begin_req) begin
        state_q <= S_START;
      end else if (started_q) begin
        state_q <= S_BYTE;
      end else begin
        state_q <= S_IDLE; // Nothing to do off the bus
      end
    end else if (start_done || byte_done) begin
      state_q <= S_HOLD;
    end else if (stop_done) begin
      state_q <= S_IDLE;
    end
  end

  // Quarter and bit counters
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      qtr_q <= `IEM_QTR_FIRST;
      bit_q <= `IEM_BIT_FIRST;
    end else if (go) begin
      qtr_q <= `IEM_QTR_FIRST;
      bit_q <= `IEM_BIT_FIRST;
    end else if (tick) begin
      qtr_q <= qtr_q + 2'h1;
      if (last && state_q == S_BYTE) begin
        bit_q <= bit_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive

  // Low level only; the wire is pulled high when released
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // Enables step by quarter; SCL kept low between actions holds the bus
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (tick) begin
      unique case (state_q)
        S_START: begin
          // Release both, then SDA falls while SCL high
          if (qtr_q == `IEM_QTR_FIRST) sda_oe_o <= 1'b0;
          if (qtr_q == `IEM_QTR_RISE) scl_oe_o <= 1'b0;
          if (qtr_q == `IEM_QTR_SAMPLE) sda_oe_o <= 1'b1;
          if (qtr_q == `IEM_QTR_LAST) scl_oe_o <= 1'b1;
        end
        S_BYTE: begin
          if (qtr_q == `IEM_QTR_FIRST) begin
            if (bit_q == `IEM_ACK_BIT) begin
              sda_oe_o <= rx_data && ack_assert_o;
            end else if (rx_data) begin
              sda_oe_o <= 1'b0;
            end else begin
              sda_oe_o <= ~shift_byte_reg_o[`IEM_MSB - bit_q[2:0]];
            end
          end
          if (qtr_q == `IEM_QTR_RISE) scl_oe_o <= 1'b0;
          if (qtr_q == `IEM_QTR_LAST) scl_oe_o <= 1'b1;
        end
        S_STOP: begin
          // SDA rises while SCL high
          if (qtr_q == `IEM_QTR_FIRST) sda_oe_o <= 1'b1;
          if (qtr_q == `IEM_QTR_RISE) scl_oe_o <= 1'b0;
          if (qtr_q == `IEM_QTR_SAMPLE) sda_oe_o <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data path

  // Software loads only while no byte is shifting; reads shift in MSB first
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_byte_reg_o <= `IEM_BYTE_RST;
    end else if (dat_wr_i && state_q != S_BYTE) begin
      shift_byte_reg_o <= dat_i;
    end else if (state_q == S_BYTE && tick && qtr_q == `IEM_QTR_SAMPLE
                 && bit_q != `IEM_ACK_BIT && rx_data) begin
      shift_byte_reg_o <= {shift_byte_reg_o[6:0], sda_i};
    end
  end

  // Ack sampled on the ninth clock
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= 1'b0;
    end else if (state_q == S_BYTE && tick && qtr_q == `IEM_QTR_SAMPLE
                 && bit_q == `IEM_ACK_BIT) begin
      ack_q <= !sda_i;
    end
  end

  // Address phase and direction tracking
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      started_q <= 1'b0;
      addr_ph_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (start_done) begin
      started_q <= 1'b1;
      addr_ph_q <= 1'b1;
    end else if (byte_done && addr_ph_q) begin
      addr_ph_q <= 1'b0;
      rd_q <= shift_byte_reg_o[0];
    end else if (stop_done) begin
      started_q <= 1'b0;
      rd_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and flag

  // Code posted at the end of each action
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_state_code_o <= `IEM_CODE_RST;
    end else if (start_done) begin
      bus_state_code_o <= started_q ? `IEM_ST_RSTART : `IEM_ST_START;
    end else if (byte_done) begin
      if (addr_ph_q && shift_byte_reg_o[0]) begin
        bus_state_code_o <= ack_q ? `IEM_ST_AR_ACK : `IEM_ST_AR_NACK;
      end else if (addr_ph_q) begin
        bus_state_code_o <= ack_q ? `IEM_ST_AW_ACK : `IEM_ST_AW_NACK;
      end else if (rd_q) begin
        bus_state_code_o <= ack_assert_o ? `IEM_ST_DR_ACK : `IEM_ST_DR_NACK;
      end else begin
        bus_state_code_o <= ack_q ? `IEM_ST_DT_ACK : `IEM_ST_DT_NACK;
      end
    end else if (stop_done) begin
      bus_state_code_o <= `IEM_ST_RELEASED;
    end
  end

  // Set wins over a clear in the same cycle; released bus raises no flag
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_o <= 1'b0;
    end else if (start_done || byte_done) begin
      flag_o <= 1'b1;
    end else if (ctl_wr_i && ctl_i.flag_clr) begin
      flag_o <= 1'b0;
    end
  end

  // Control bits; halt request self-clears once the bus is free
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      begin_cond_request_o <= 1'b0;
      halt_cond_request_o <= 1'b0;
      ack_assert_o <= 1'b0;
    end else if (ctl_wr_i) begin
      begin_cond_request_o <= ctl_i.begin_req;
      halt_cond_request_o <= ctl_i.halt_req;
      ack_assert_o <= ctl_i.ack_assert;
    end else if (stop_done) begin
      halt_cond_request_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [8:0] gap_q; // Clocks since previous tick
  logic seen_q; // A tick occurred in this run
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap_q <= 9'h000;
      seen_q <= 1'b0;
    end else if (!run) begin
      gap_q <= 9'h000;
      seen_q <= 1'b0;
    end else if (tick) begin
      gap_q <= 9'h001;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 9'h001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_start_code: assert property (start_done && !started_q |=>
    bus_state_code_o == `IEM_ST_START && flag_o) else $error("START code wrong");
  a_rstart_code: assert property (start_done && started_q |=>
    bus_state_code_o == `IEM_ST_RSTART && flag_o) else $error("repeated START code wrong");
  a_hold_bus: assert property (state_q == S_HOLD && !go |=>
    state_q == S_HOLD && scl_oe_o) else $error("bus not held");
  a_addr_ack: assert property (byte_done && addr_ph_q && !shift_byte_reg_o[0] |=>
    bus_state_code_o == (ack_q ? `IEM_ST_AW_ACK : `IEM_ST_AW_NACK)) else $error("addr code");
  a_data_ack: assert property (byte_done && !addr_ph_q && !rd_q |=>
    bus_state_code_o == ($past(ack_q) ? `IEM_ST_DT_ACK : `IEM_ST_DT_NACK))
    else $error("data code");
  a_rx_nack: assert property (state_q == S_BYTE && tick && qtr_q == `IEM_QTR_FIRST
    && bit_q == `IEM_ACK_BIT && rx_data && !ack_assert_o |=> !sda_oe_o) else $error("no nack");
  a_rx_code: assert property (byte_done && rx_data && !ack_assert_o |=>
    bus_state_code_o == `IEM_ST_DR_NACK) else $error("rx code");
  a_go_select: assert property (go && ctl_i.halt_req && started_q |=>
    state_q == S_STOP) else $error("STOP not chosen");
  a_flag_set: assert property ((start_done || byte_done) |=> flag_o)
    else $error("flag not set");
  a_tick_rate: assert property (tick && seen_q && run |->
    gap_q == {1'b0, rate_divider_i} + 9'h001) else $error("bit rate wrong");
  a_halt_clear: assert property (stop_done && !ctl_wr_i |=>
    !halt_cond_request_o && !sda_oe_o && !scl_oe_o) else $error("halt not cleared");
  a_msb_first: assert property (state_q == S_BYTE && tick && qtr_q == `IEM_QTR_FIRST
    && bit_q == `IEM_BIT_FIRST && !rx_data |=> sda_oe_o == ~shift_byte_reg_o[7])
    else $error("MSB not first");
endmodule

// ### sim/iem_ee_model.sv
// Behavioural serial EEPROM on the far side of the two-wire bus
`timescale 1ns/100ps
module iem_ee_model #(
  parameter logic [6:0] TARGET_ID = 7'h50
) (
  // Bus wires
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  // Fault control and observation
  input wire logic nack_data_i,
  output logic mst_ack_o
);
  int bit_n = 0; // Bits seen in this byte
  int byte_n = 0; // Bytes since last START
  logic rd_q = 1'b0; // Returning data
  logic sel_q = 1'b0; // Own address seen
  logic [7:0] sh_q = 8'h00; // Incoming bits
  logic [7:0] out_q = 8'h00; // Outgoing byte
  logic [15:0] ptr_q = 16'h0000; // Internal pointer
  initial sda_oe_o = 1'b0;
  initial mst_ack_o = 1'b0;
  ////////////////////////////////////////////////////////////////
  // START or repeated START restarts byte framing
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      bit_n = 0;
      byte_n = 0;
      rd_q = 1'b0;
    end
  end
  // STOP deselects; line released so the pull-up wins
  always @(posedge sda_i) begin
    if (scl_i === 1'b1) begin
      sel_q = 1'b0;
      rd_q = 1'b0;
      sda_oe_o = 1'b0;
    end
  end
  // Sample on the rising clock, MSB first; ninth bit is acknowledge
  always @(posedge scl_i) begin
    if (bit_n < 8) sh_q = {sh_q[6:0], sda_i};
    else mst_ack_o = !sda_i;
    bit_n++;
  end
  // Drive only while the clock is low, so no false START or STOP
  always @(negedge scl_i) begin
    if (bit_n == 8 && byte_n == 0) begin // Address byte done
      sel_q = (sh_q[7:1] == TARGET_ID);
      rd_q = sh_q[0] & sel_q;
      out_q = ptr_q[7:0] ^ ptr_q[15:8] ^ 8'hA5;
      sda_oe_o = sel_q;
    end else if (bit_n == 8 && !rd_q) begin // Pointer byte
      ptr_q = {ptr_q[7:0], sh_q};
      sda_oe_o = sel_q & !nack_data_i;
    end else if (bit_n == 9) begin // Stop sending after master refusal
      rd_q = rd_q & (byte_n == 0 || mst_ack_o);
      bit_n = 0;
      byte_n++;
      sda_oe_o = rd_q & !out_q[7];
    end else if (rd_q && bit_n < 8) begin
      sda_oe_o = !out_q[7 - bit_n];
    end else begin
      sda_oe_o = 1'b0;
    end
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the EEPROM random-read master
`timescale 1ns/100ps
`include "iem_consts.svh"
module tb_top;
  import iem_pkg::*;
  localparam logic [6:0] ID = 7'h50; // Model's own address
  logic clk_i, arst_n_i, ctl_wr_i, dat_wr_i;
  iem_ctl_t ctl_i;
  logic [7:0] dat_i, rate_divider_i, code, shb;
  logic flag_o, beg, halt_cond_request_o, aa, scl_oe_o, sda_oe_o, ee_oe, nack_d, mst_ack;
  logic scl_lv, sda_lv; // Levels the master drives while enabled
  int exp_q[$]; // Expected read bytes, oldest first
  logic scl_prev = 1'b1;
  logic [15:0] per_cnt = 16'h0000, last_per = 16'h0000; // Clocks between rises
  int n_errors, cmp_count, seed, cyc = 0;
  wire scl_w = scl_oe_o ? scl_lv : 1'b1; // Pull-up lines
  wire sda_w = (sda_oe_o ? sda_lv : 1'b1) & !ee_oe;
  ////////////////////////////////////////////////////////////////
  iem_ctrl DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .ctl_wr_i(ctl_wr_i), .ctl_i(ctl_i),
    .dat_wr_i(dat_wr_i), .dat_i(dat_i), .rate_divider_i(rate_divider_i), .flag_o(flag_o),
    .bus_state_code_o(code), .shift_byte_reg_o(shb), .begin_cond_request_o(beg),
    .halt_cond_request_o(halt_cond_request_o), .ack_assert_o(aa), .scl_i(scl_w),
    .scl_o(scl_lv), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_lv), .sda_oe_o(sda_oe_o));
  iem_ee_model #(.TARGET_ID(ID)) ee (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(ee_oe),
    .nack_data_i(nack_d), .mst_ack_o(mst_ack));
  always #5 clk_i = !clk_i;
  // Serial clock period, measured rise to rise
  always @(posedge clk_i) begin
    scl_prev <= scl_w;
    per_cnt <= (scl_w && !scl_prev) ? 16'h0001 : per_cnt + 16'h0001;
    if (scl_w && !scl_prev) last_per <= per_cnt;
    cyc++;
    if (cyc == 60000) begin // Far above the longest planned run
      n_errors++;
      $display("unexpected hang at %0t: got %h expected %h", $time, cyc, 0);
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk_code(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected code at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic [7:0] d);
    @(negedge clk_i);
    dat_i = d;
    dat_wr_i = 1'b1;
    @(negedge clk_i);
    dat_wr_i = 1'b0;
  endtask
  // Write control bits with the flag-clear bit set
  task automatic ctl(input logic b, input logic h, input logic a);
    @(negedge clk_i);
    ctl_i = {b, h, 1'b1, a};
    ctl_wr_i = 1'b1;
    @(negedge clk_i);
    ctl_wr_i = 1'b0;
  endtask
  // Launch one action, wait for the flag, then confirm the bus stays held
  task automatic act(input logic b, input logic [7:0] exp, input logic a = 1'b0);
    int n;
    ctl(b, 1'b0, a);
    for (n = 0; n < 4000 && flag_o !== 1'b1; n++) @(negedge clk_i);
    chk_code(code, exp);
    repeat (8) @(negedge clk_i);
    chk_val({flag_o, scl_oe_o, beg, aa}, {12'h000, 2'b11, b, a});
  endtask
  task automatic stop_bus;
    int n;
    ctl(1'b0, 1'b1, 1'b0);
    for (n = 0; n < 4000 && halt_cond_request_o !== 1'b0; n++) @(negedge clk_i);
    repeat (4) @(negedge clk_i);
    chk_code(code, `IEM_ST_RELEASED);
    chk_val({halt_cond_request_o, sda_oe_o, scl_oe_o}, 16'h0000);
  endtask
  task automatic xfer(input logic [6:0] id, input logic [15:0] ptr, input logic nd);
    nack_d = nd;
    act(1'b1, `IEM_ST_START);
    load({id, 1'b0});
    act(1'b0, (id == ID) ? `IEM_ST_AW_ACK : `IEM_ST_AW_NACK);
    chk_val(last_per, 16'(4 * (int'(rate_divider_i) + 1)));
    if (id != ID) begin
      stop_bus();
      return;
    end
    load(ptr[15:8]);
    act(1'b0, nd ? `IEM_ST_DT_NACK : `IEM_ST_DT_ACK);
    if (nd) begin
      stop_bus();
      return;
    end
    load(ptr[7:0]);
    act(1'b0, `IEM_ST_DT_ACK);
    act(1'b1, `IEM_ST_RSTART);
    load({id, 1'b1});
    act(1'b0, `IEM_ST_AR_ACK);
    exp_q.push_back(int'(ptr[7:0] ^ ptr[15:8] ^ 8'hA5)); // Partner's byte at this pointer
    act(1'b0, `IEM_ST_DR_ACK, 1'b1);
    chk_val({8'h00, shb}, 16'(exp_q[0]));
    act(1'b0, `IEM_ST_DR_NACK);
    chk_val({8'h00, shb}, 16'(exp_q.pop_front()));
    chk_val({15'h0000, mst_ack}, 16'h0000);
    stop_bus();
  endtask
  task automatic rd(input logic [6:0] id, input logic [15:0] ptr, input logic nd);
    xfer(id, ptr, nd);
    $display("test done: id %h pointer %h errors %0d", id, ptr, n_errors);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    arst_n_i = 1'b0;
    {ctl_wr_i, dat_wr_i, nack_d} = 3'h0;
    ctl_i = '0;
    dat_i = 8'h00;
    rate_divider_i = 8'h0A;
    n_errors = 0;
    cmp_count = 0;
    seed = 99136;
    repeat (20) @(negedge clk_i);
    arst_n_i = 1'b1;
    chk_code(code, `IEM_CODE_RST);
    for (int t = 0; t < 6; t++) begin
      rd(ID, 16'($random(seed)), 1'b0);
      rate_divider_i = 8'($unsigned($random(seed)) % 4);
    end
    rd(7'h13, 16'h0000, 1'b0);
    rd(ID, 16'($random(seed)), 1'b1);
    summarize();
  end
endmodule
